// ===== hw/adsc_map.svh
/*
  Register offsets, field positions, reset values and timing counts of
  the converter sequencing block. Assumes byte addresses on a 12-bit
  register port with 16-bit data.
*/
`ifndef ADSC_MAP_SVH
`define ADSC_MAP_SVH

`define ADSC_AW          12
`define ADSC_DW          16
`define ADSC_BUF_BASE    12'h280
`define ADSC_BUF_LAST    12'h29E
`define ADSC_CTRL1       12'h2A0
`define ADSC_CTRL2       12'h2A2
`define ADSC_CTRL3       12'h2A4
`define ADSC_INSEL       12'h2A6
`define ADSC_PCFG        12'h2A8
`define ADSC_PORTV       12'h2AA

`define ADSC_C1_ON       15
`define ADSC_C1_SIDL     13
`define ADSC_C1_FORM     8
`define ADSC_C1_SSRC     5
`define ADSC_C1_SIMULTANEOUS_SAMPLE_SEL   3
`define ADSC_C1_AUTO_SAMPLE_EN     2
`define ADSC_C1_ACQUIRE_CTRL     1
`define ADSC_C1_DONE     0
`define ADSC_C1_MASK     16'hA3EC
`define ADSC_C2_CHPS     8
`define ADSC_C2_SMPI     2
`define ADSC_C2_MASK     16'h033C
`define ADSC_C3_SAMC     8
`define ADSC_C3_RC       7
`define ADSC_C3_ADCS     0
`define ADSC_C3_MASK     16'h1FBF
`define ADSC_INSEL_CH0   0
`define ADSC_INSEL_CHX   4
`define ADSC_INSEL_MASK  16'h00FF

`define ADSC_RST_REG     16'h0000
`define ADSC_SSRC_MANUAL 3'h0
`define ADSC_SSRC_EXT    3'h1
`define ADSC_SSRC_AUTO   3'h7
`define ADSC_CONV_TADS   4'hB
`define ADSC_MIN_SAMC    5'h01
`define ADSC_CLK_NS      50

`endif

// ===== hw/adsc_pkg.sv
/*
  Types of the converter sequencing block. Assumes adsc_map.svh for
  all numeric constants.
*/
package adsc_pkg;

  typedef enum logic [2:0] {
    ADSC_IDLE,
    ADSC_SAMPLE,
    ADSC_WAIT,
    ADSC_CONV
  } adsc_state_t;

  typedef enum logic [1:0] {
    ADSC_FMT_INT,
    ADSC_FMT_SINT,
    ADSC_FMT_FRAC,
    ADSC_FMT_SFRAC
  } adsc_fmt_t;

endpackage : adsc_pkg

// ===== hw/adsc_top.sv
/*
  Sequencing and register logic of a 10-bit successive-approximation
  converter: sampling, conversion timing, result buffer, read formats,
  power, sleep and idle behaviour. Assumes a 20 MHz core clock equal to
  the instruction rate and quantised analog levels from the front end.
*/
`timescale 1ns/10ps
`include "adsc_map.svh"

module adsc_top
  import adsc_pkg::*;
#(
  parameter int unsigned NPINS  = 16,
  parameter int unsigned RC_DIV = 3
) (
  // Clock and reset.
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_i,
  // Register port.
  input  wire logic [`ADSC_AW-1:0]     reg_addr_i,
  input  wire logic [`ADSC_DW-1:0]     reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [`ADSC_DW-1:0]     reg_rdata_o,
  // Processor state.
  input  wire logic                    cpu_sleep_i,
  input  wire logic                    cpu_idle_i,
  input  wire logic                    irq_enable_i,
  // Pins and analog front end.
  input  wire logic                    ext_trigger_i,
  input  wire logic [NPINS-1:0]        pin_level_i,
  input  wire logic [NPINS-1:0]        pin_direction_i,
  input  wire logic [NPINS*10-1:0]     ain_level_i,
  // Status.
  output logic                         irq_req_o,
  output logic                         wake_o,
  output logic                         module_active_o,
  output logic                         converting_o
);

  localparam int unsigned PW = $clog2(NPINS);

  adsc_state_t             state_q;
  logic [15:0]             c1_q;
  logic [15:0]             c2_q;
  logic [15:0]             c3_q;
  logic [15:0]             insel_q;
  logic [NPINS-1:0]        pcfg_q;
  logic                    acquire_ctrl_q;
  logic                    done_q;
  logic [9:0]              buf_mem [16];
  logic [9:0]              held_q [4];
  logic [3:0]              wp_q;
  logic [3:0]              ncv_q;
  logic [1:0]              ci_q;
  logic [3:0]              tad_q;
  logic [4:0]              scnt_q;
  logic [5:0]              div_q;
  logic                    sleep_off_q;
  logic [NPINS:0]          s1_q;
  logic [NPINS:0]          s2_q;
  logic [NPINS:0]          s3_q;
  logic [NPINS:0]          stab_q;
  logic                    trig_prev_q;
  logic [15:0]             rdata_q;
  logic                    irq_q;
  logic                    wake_q;
  logic                    active_q;
  logic                    conv_q;

  logic                    on;
  logic                    rc;
  logic                    freeze;
  logic                    abort;
  logic                    busy;
  logic                    tick;
  logic [5:0]              div_lim;
  logic [1:0]              last_ch;
  logic [4:0]              samc;
  logic [2:0]              ssrc;
  logic                    trig_edge;
  logic                    acquire_ctrl_end;
  logic                    conv_done;
  logic                    seq_end;
  logic                    wr_buf;
  logic [3:0]              widx;
  logic [9:0]              live [4];

  function automatic logic [15:0] fmt_word(input logic [1:0] f,
                                           input logic [9:0] d);
    logic [15:0] w;
    w = {6'h00, d};
    case (adsc_fmt_t'(f))
      ADSC_FMT_INT:   w = {6'h00, d};
      ADSC_FMT_SINT:  w = {{6{d[9]}}, d};
      ADSC_FMT_FRAC:  w = {d, 6'h00};
      ADSC_FMT_SFRAC: w = {d, 6'h00};
      default:        w = {6'h00, d};
    endcase
    return w;
  endfunction : fmt_word

  function automatic logic [9:0] pin_sample(input logic [PW-1:0] p,
                                            input logic [NPINS-1:0] cfg,
                                            input logic [NPINS-1:0] dir,
                                            input logic [NPINS-1:0] lvl,
                                            input logic [NPINS*10-1:0] a);
    logic [9:0] v;
    v = a[p*10 +: 10];
    if (cfg[p]) begin
      v = 10'h000;
    end else if (!dir[p]) begin
      v = {10{lvl[p]}};
    end
    return v;
  endfunction : pin_sample

  assign on      = c1_q[`ADSC_C1_ON];
  assign rc      = c3_q[`ADSC_C3_RC];
  assign ssrc    = c1_q[`ADSC_C1_SSRC +: 3];
  assign samc    = c3_q[`ADSC_C3_SAMC +: 5];
  assign freeze  = cpu_idle_i & c1_q[`ADSC_C1_SIDL];
  // Without the RC clock the module loses its clock in sleep.
  assign abort   = !on | sleep_off_q | (cpu_sleep_i & !rc);
  assign busy    = (state_q != ADSC_IDLE);
  assign last_ch = (c2_q[`ADSC_C2_CHPS +: 2] == 2'h0) ? 2'h0 :
                   (c2_q[`ADSC_C2_CHPS +: 2] == 2'h1) ? 2'h1 : 2'h3;
  // The half-cycle step of the divider is rounded up to whole cycles.
  assign div_lim = rc ? 6'(RC_DIV) : {1'b0, c3_q[`ADSC_C3_ADCS+1 +: 5]};
  assign tick    = busy & !freeze & (div_q == div_lim);
  assign trig_edge = stab_q[NPINS] & !trig_prev_q;

  // Channel 0 has its own selector, the others share one, so software
  // can route one pin to two channels.
  always_comb begin
    live[0] = pin_sample(insel_q[`ADSC_INSEL_CH0 +: PW], pcfg_q,
                         pin_direction_i, stab_q[NPINS-1:0], ain_level_i);
    for (int k = 1; k < 4; k++) begin
      live[k] = pin_sample(insel_q[`ADSC_INSEL_CHX +: PW], pcfg_q,
                           pin_direction_i, stab_q[NPINS-1:0],
                           ain_level_i);
    end
  end

  always_comb begin
    acquire_ctrl_end = 1'b0;
    if (state_q == ADSC_SAMPLE && !abort && !freeze) begin
      case (ssrc)
        `ADSC_SSRC_MANUAL: acquire_ctrl_end = !acquire_ctrl_q;
        `ADSC_SSRC_AUTO:   acquire_ctrl_end = tick &&
          (scnt_q + 5'h01 >= ((samc == 5'h00) ?
                              `ADSC_MIN_SAMC : samc));
        default:           acquire_ctrl_end = trig_edge;
      endcase
    end
  end

  assign conv_done = (state_q == ADSC_CONV) && !abort && tick &&
                     (tad_q == `ADSC_CONV_TADS);
  assign seq_end   = conv_done && (ci_q == last_ch);
  assign wr_buf    = reg_wr_i && reg_addr_i >= `ADSC_BUF_BASE &&
                     reg_addr_i <= `ADSC_BUF_LAST && !reg_addr_i[0];
  assign widx      = reg_addr_i[4:1];

  // Pin inputs: a bit moves once the second and third stages agree.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q        <= '0;
      s2_q        <= '0;
      s3_q        <= '0;
      stab_q      <= '0;
      trig_prev_q <= 1'b0;
    end else begin
      s1_q        <= {ext_trigger_i, pin_level_i};
      s2_q        <= s1_q;
      s3_q        <= s2_q;
      stab_q      <= (s2_q & s3_q) | (stab_q & (s2_q | s3_q));
      trig_prev_q <= stab_q[NPINS];
    end
  end

  // Control registers; sleep never touches them.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      c1_q    <= `ADSC_RST_REG;
      c2_q    <= `ADSC_RST_REG;
      c3_q    <= `ADSC_RST_REG;
      insel_q <= `ADSC_RST_REG;
      pcfg_q  <= '0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `ADSC_CTRL1: c1_q    <= reg_wdata_i & `ADSC_C1_MASK;
        `ADSC_CTRL2: c2_q    <= reg_wdata_i & `ADSC_C2_MASK;
        `ADSC_CTRL3: c3_q    <= reg_wdata_i & `ADSC_C3_MASK;
        `ADSC_INSEL: insel_q <= reg_wdata_i & `ADSC_INSEL_MASK;
        `ADSC_PCFG:  pcfg_q  <= reg_wdata_i[NPINS-1:0];
        default:     c1_q    <= c1_q;
      endcase
    end
  end

  // Acquire bit: switch-off clear, then auto set, then hardware clear, then software write.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acquire_ctrl_q <= 1'b0;
    end else if (!on) begin
      acquire_ctrl_q <= 1'b0;
    end else if (state_q == ADSC_IDLE && !freeze && !abort &&
                 c1_q[`ADSC_C1_AUTO_SAMPLE_EN]) begin
      acquire_ctrl_q <= 1'b1;
    end else if (acquire_ctrl_end) begin
      acquire_ctrl_q <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == `ADSC_CTRL1) begin
      acquire_ctrl_q <= reg_wdata_i[`ADSC_C1_ACQUIRE_CTRL];
    end
  end

  // Done flag: a completion in the clearing cycle wins.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else if (conv_done) begin
      done_q <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == `ADSC_CTRL1) begin
      done_q <= reg_wdata_i[`ADSC_C1_DONE];
    end
  end

  // Sequencer.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ADSC_IDLE;
      ci_q    <= 2'h0;
    end else if (abort) begin
      state_q <= ADSC_IDLE;
      ci_q    <= 2'h0;
    end else if (!freeze) begin
      case (state_q)
        ADSC_IDLE: begin
          if (acquire_ctrl_q) begin
            state_q <= ADSC_SAMPLE;
          end
        end
        ADSC_SAMPLE: begin
          if (acquire_ctrl_end) begin
            ci_q    <= 2'h0;
            state_q <= rc ? ADSC_WAIT : ADSC_CONV;
          end
        end
        ADSC_WAIT: begin
          state_q <= ADSC_CONV;
        end
        ADSC_CONV: begin
          if (seq_end) begin
            state_q <= ADSC_IDLE;
            ci_q    <= 2'h0;
          end else if (conv_done) begin
            ci_q    <= ci_q + 2'h1;
          end
        end
        default: begin
          state_q <= ADSC_IDLE;
        end
      endcase
    end
  end

  // Held values. Sequential mode lets each channel keep acquiring until
  // its own conversion starts.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int k = 0; k < 4; k++) begin
        held_q[k] <= 10'h000;
      end
    end else if (acquire_ctrl_end) begin
      for (int k = 0; k < 4; k++) begin
        if (c1_q[`ADSC_C1_SIMULTANEOUS_SAMPLE_SEL] || k == 0) begin
          held_q[k] <= live[k];
        end
      end
    end else if (conv_done && !seq_end &&
                 !c1_q[`ADSC_C1_SIMULTANEOUS_SAMPLE_SEL]) begin
      held_q[ci_q + 2'h1] <= live[ci_q + 2'h1];
    end
  end

  // Conversion clock divider and counters.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q  <= 6'h00;
      tad_q  <= 4'h0;
      scnt_q <= 5'h00;
    end else if (!busy || abort) begin
      div_q  <= 6'h00;
      tad_q  <= 4'h0;
      scnt_q <= 5'h00;
    end else if (!freeze) begin
      div_q <= tick ? 6'h00 : div_q + 6'h01;
      if (state_q == ADSC_SAMPLE && tick) begin
        scnt_q <= scnt_q + 5'h01;
      end
      if (state_q != ADSC_CONV || conv_done) begin
        tad_q <= 4'h0;
      end else if (tick) begin
        tad_q <= tad_q + 4'h1;
      end
    end
  end

  // Buffer pointer, interrupt spacing, sleep results.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_q        <= 4'h0;
      ncv_q       <= 4'h0;
      irq_q       <= 1'b0;
      wake_q      <= 1'b0;
      sleep_off_q <= 1'b0;
    end else begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
      if (!cpu_sleep_i) begin
        sleep_off_q <= 1'b0;
      end
      if (!on) begin
        wp_q  <= 4'h0;
        ncv_q <= 4'h0;
      end else if (conv_done) begin
        if (ncv_q == c2_q[`ADSC_C2_SMPI +: 4]) begin
          irq_q <= 1'b1;
          wp_q  <= 4'h0;
          ncv_q <= 4'h0;
        end else begin
          wp_q  <= wp_q + 4'h1;
          ncv_q <= ncv_q + 4'h1;
        end
        if (cpu_sleep_i && irq_enable_i) begin
          wake_q <= 1'b1;
        end else if (cpu_sleep_i) begin
          sleep_off_q <= 1'b1;
        end
      end
    end
  end

  // Result store has no reset so contents survive a device reset.
  always_ff @(posedge core_clk_i) begin
    if (conv_done) begin
      buf_mem[wp_q] <= held_q[ci_q];
    end
    if (wr_buf && !(conv_done && widx == wp_q)) begin
      buf_mem[widx] <= reg_wdata_i[9:0];
    end
  end

  // Read port, data one cycle after the strobe.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i >= `ADSC_BUF_BASE &&
          reg_addr_i <= `ADSC_BUF_LAST && !reg_addr_i[0]) begin
        rdata_q <= fmt_word(c1_q[`ADSC_C1_FORM +: 2],
                            buf_mem[reg_addr_i[4:1]]);
      end else begin
        case (reg_addr_i)
          `ADSC_CTRL1: begin
            rdata_q <= c1_q;
            rdata_q[`ADSC_C1_ACQUIRE_CTRL] <= acquire_ctrl_q;
            rdata_q[`ADSC_C1_DONE] <= done_q;
          end
          `ADSC_CTRL2: rdata_q <= c2_q;
          `ADSC_CTRL3: rdata_q <= c3_q;
          `ADSC_INSEL: rdata_q <= insel_q;
          `ADSC_PCFG:  rdata_q <= 16'(pcfg_q);
          `ADSC_PORTV: rdata_q <= 16'(stab_q[NPINS-1:0] & pcfg_q);
          default:     rdata_q <= 16'h0000;
        endcase
      end
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // Status flops.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_q <= 1'b0;
      conv_q   <= 1'b0;
    end else begin
      active_q <= on && !sleep_off_q && !freeze;
      conv_q   <= (state_q == ADSC_CONV) && !abort;
    end
  end

  assign reg_rdata_o     = rdata_q;
  assign irq_req_o       = irq_q;
  assign wake_o          = wake_q;
  assign module_active_o = active_q;
  assign converting_o    = conv_q;

endmodule : adsc_top

// ===== test/adsc_ain_model.sv
/*
  Analog front end model: a fixed quantised level on every pin and a
  fixed digital pattern on the pin pads. Assumes the bench derives its
  expected results from the same level and pattern parameters it hands in here.
*/
`timescale 1ns/10ps
module adsc_ain_model #(
  parameter int unsigned NPINS    = 16,
  parameter logic [9:0]  LVL_BASE = 10'h2A5,
  parameter logic [9:0]  LVL_STEP = 10'h013,
  parameter logic [15:0] PATTERN  = 16'hA5C3,
  parameter logic [15:0] PIN_DIR  = 16'hFFFF
) (
  // Pin side of the converter.
  output logic [NPINS*10-1:0] ain_level_o,
  output logic [NPINS-1:0]    pin_level_o,
  output logic [NPINS-1:0]    pin_direction_o
);
  // Levels differ per pin so a wrong channel select shows up at once.
  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      ain_level_o[p*10+:10] = LVL_BASE + LVL_STEP * 10'(p);
    end
  end

  assign pin_level_o     = PATTERN[NPINS-1:0];
  assign pin_direction_o = PIN_DIR[NPINS-1:0];
endmodule : adsc_ain_model

// ===== test/adsc_top_properties.sv
/*
  Concurrent checks on the ports of adsc_top. Assumes the register map
  header and a bind to every adsc_top instance.
*/
`timescale 1ns/10ps
`include "adsc_map.svh"
module adsc_top_checker (
  // Clock and reset.
  input wire logic                core_clk_i,
  input wire logic                rst_i,
  // Register port.
  input wire logic [`ADSC_AW-1:0] reg_addr_i,
  input wire logic [`ADSC_DW-1:0] reg_wdata_i,
  input wire logic                reg_wr_i,
  input wire logic                reg_rd_i,
  input wire logic [`ADSC_DW-1:0] reg_rdata_o,
  // Processor state.
  input wire logic                cpu_sleep_i,
  input wire logic                cpu_idle_i,
  input wire logic                irq_enable_i,
  // Status.
  input wire logic                irq_req_o,
  input wire logic                wake_o,
  input wire logic                module_active_o,
  input wire logic                converting_o
);
  // Shadows of control words, so no check has to look inside the design.
  logic [15:0] c1_q;
  logic [15:0] c3_q;
  logic [15:0] pcfg_q;
  logic        buf_rd;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      c1_q <= `ADSC_RST_REG;
    end else if (reg_wr_i && reg_addr_i == `ADSC_CTRL1) begin
      c1_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      c3_q <= `ADSC_RST_REG;
    end else if (reg_wr_i && reg_addr_i == `ADSC_CTRL3) begin
      c3_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pcfg_q <= `ADSC_RST_REG;
    end else if (reg_wr_i && reg_addr_i == `ADSC_PCFG) begin
      pcfg_q <= reg_wdata_i;
    end
  end

  assign buf_rd = reg_rd_i && !reg_addr_i[0] && reg_addr_i >= `ADSC_BUF_BASE
                  && reg_addr_i <= `ADSC_BUF_LAST;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_OFF_INACTIVE: assert property (
    !c1_q[15] && $past(!c1_q[15]) |-> !module_active_o)
    else $error("module active while switched off");
  AST_ON_ACTIVE: assert property (
    $past(c1_q[15] && !cpu_sleep_i && !(cpu_idle_i && c1_q[13]))
    && $past(!cpu_sleep_i, 2) && $past(!cpu_sleep_i, 3) |-> module_active_o)
    else $error("module inactive while switched on and running");
  AST_IDLE_STOP: assert property (
    $past(cpu_idle_i && c1_q[13]) |-> !module_active_o)
    else $error("module kept running in idle with stop selected");
  AST_OFF_NO_CONV: assert property (
    !c1_q[15] [*3] |=> !converting_o)
    else $error("conversion running while switched off");
  AST_SLEEP_ABORT: assert property (
    (cpu_sleep_i && !c3_q[7]) [*3] |=> !converting_o)
    else $error("conversion kept running in sleep without rc clock");
  AST_WAKE_CAUSE: assert property (
    wake_o |-> $past(cpu_sleep_i && irq_enable_i) ##1 !wake_o)
    else $error("wake pulse without sleep and enabled interrupt");
  AST_IRQ_AFTER_CONV: assert property (
    irq_req_o |-> $past(converting_o) ##1 !irq_req_o)
    else $error("interrupt request not tied to a finished conversion");
  AST_SAMPLE_GAP: assert property (
    $fell(converting_o) |=> !converting_o)
    else $error("no sampling time between conversions");
  AST_PORT_ANALOG_ZERO: assert property (
    reg_rd_i && reg_addr_i == `ADSC_PORTV |=> (reg_rdata_o & ~pcfg_q) == 0)
    else $error("analog pin read as nonzero on the port");
  AST_FMT_INT: assert property (
    buf_rd && c1_q[9:8] == 2'h0 |=> reg_rdata_o[15:10] == 6'h00)
    else $error("integer format upper bits not zero");
  AST_FMT_SINT: assert property (
    buf_rd && c1_q[9:8] == 2'h1 |=> reg_rdata_o[15:10] == {6{reg_rdata_o[9]}})
    else $error("signed integer format not sign extended");
  AST_FMT_FRAC: assert property (
    buf_rd && c1_q[9] |=> reg_rdata_o[5:0] == 6'h00)
    else $error("fractional format lower bits not zero");

  COV_WAKE: cover property (wake_o);
  COV_IRQ: cover property (irq_req_o);
  COV_FRAC_READ: cover property (buf_rd && c1_q[9]);
endmodule : adsc_top_checker

bind adsc_top adsc_top_checker u_checker (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .cpu_sleep_i(cpu_sleep_i),
  .cpu_idle_i(cpu_idle_i), .irq_enable_i(irq_enable_i),
  .irq_req_o(irq_req_o), .wake_o(wake_o),
  .module_active_o(module_active_o), .converting_o(converting_o)
);

// ===== test/adsc_top_test.sv
/*
  Self-checking bench of adsc_top: register tasks, conversions, formats,
  reset, sleep, idle and interrupt spacing. Assumes adsc_ain_model on
  the pin side and the checker bound from adsc_top_properties.sv.
*/
`timescale 1ns/10ps
`include "adsc_map.svh"
module adsc_top_test;
  localparam logic [9:0]  LVL_BASE = 10'h2A5;
  localparam logic [9:0]  LVL_STEP = 10'h013;
  localparam logic [15:0] PATTERN  = 16'hA5C3;
  // Pin 7 is an output, so it converts its own driven level.
  localparam logic [15:0] DIR_PINS = 16'hFF7F;
  localparam int          LIMIT    = 20000;

  logic          core_clk, rst, wr_s, rd_s, sleep, idle, irq_en, trig;
  logic [11:0]   addr;
  logic [15:0]   wdata, rdata, rv, pin_lvl, pin_dir;
  logic [159:0]  ain;
  logic          irq_req, wake, active, converting, conv_p;
  int            num_errors, tests_run, cyc, nirq, nconv, nwake, k, base;

  adsc_ain_model #(.LVL_BASE(LVL_BASE), .LVL_STEP(LVL_STEP),
    .PATTERN(PATTERN), .PIN_DIR(DIR_PINS)) u_ain (.ain_level_o(ain),
    .pin_level_o(pin_lvl),
    .pin_direction_o(pin_dir));

  adsc_top dut (
    .core_clk_i(core_clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_rdata_o(rdata), .cpu_sleep_i(sleep), .cpu_idle_i(idle),
    .irq_enable_i(irq_en), .ext_trigger_i(trig), .pin_level_i(pin_lvl),
    .pin_direction_i(pin_dir), .ain_level_i(ain), .irq_req_o(irq_req),
    .wake_o(wake), .module_active_o(active), .converting_o(converting)
  );

  function automatic logic [9:0] lvl(input int p);
    lvl = LVL_BASE + LVL_STEP * 10'(p);
  endfunction : lvl

  function automatic logic [15:0] fmt(input logic [1:0] f,
                                      input logic [9:0] d);
    case (f)
      2'h0: fmt = {6'h00, d};
      2'h1: fmt = {{6{d[9]}}, d};
      default: fmt = {d, 6'h00};
    endcase
  endfunction : fmt

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge core_clk);
    wr_s  <= 1'b0;
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge core_clk);
    rd_s <= 1'b0;
    @(negedge core_clk);
    rv = rdata;
    chk(rv, exp);
  endtask : rc

  // Manual sampling: acquire, then clearing the bit starts conversion.
  // The module is switched on first, since an acquire bit written while
  // it is off is dropped.
  task automatic convert;
    wr(`ADSC_CTRL1, 16'h8000);
    wr(`ADSC_CTRL1, 16'h8002);
    repeat (4) @(posedge core_clk);
    wr(`ADSC_CTRL1, 16'h8000);
  endtask : convert

  task automatic reset_dut;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
  endtask : reset_dut

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Event counters and the hang limit share one clocked monitor.
  always @(posedge core_clk) begin
    cyc++;
    nirq += irq_req;
    nwake += wake;
    nconv += (conv_p && !converting);
    conv_p = converting;
    if (cyc > LIMIT) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    {rst, wr_s, rd_s, sleep, idle, irq_en, trig, conv_p} = 8'h80;
    addr = 12'h000;
    wdata = 16'h0000;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 12'h2A0; a <= 12'h2AC; a += 2) rc(12'(a), 16'h0000);
    wr(`ADSC_PCFG, 16'h00F0);
    rc(`ADSC_PORTV, PATTERN & 16'h00F0);
    wr(`ADSC_PCFG, 16'h0000);
    wr(`ADSC_INSEL, 16'h0005);
    convert();
    repeat (30) @(posedge core_clk);
    rc(`ADSC_CTRL1, 16'h8001);
    wr(`ADSC_BUF_BASE + 12'h002, 16'hFD55);
    for (int f = 0; f < 4; f++) begin
      wr(`ADSC_CTRL1, {6'h20, 2'(f), 8'h00});
      rc(`ADSC_BUF_BASE, fmt(2'(f), lvl(5)));
      rc(`ADSC_BUF_BASE + 12'h002, fmt(2'(f), 10'h155));
    end
    // A reset in mid-conversion must not touch the stored result.
    wr(`ADSC_INSEL, 16'h0004);
    convert();
    repeat (4) @(posedge core_clk);
    reset_dut();
    rc(`ADSC_INSEL, 16'h0000);
    rc(`ADSC_BUF_BASE, fmt(2'h0, lvl(5)));
    wr(`ADSC_INSEL, 16'h0005);
    wr(`ADSC_PCFG, 16'h0020);
    convert();
    repeat (30) @(posedge core_clk);
    rc(`ADSC_BUF_BASE, 16'h0000);
    wr(`ADSC_PCFG, 16'h0000);
    wr(`ADSC_CTRL2, 16'h0004);
    convert();
    for (k = 0; k < 50 && converting !== 1'b1; k++) @(negedge core_clk);
    @(posedge core_clk);
    sleep <= 1'b1;
    repeat (20) @(posedge core_clk);
    sleep <= 1'b0;
    rc(`ADSC_CTRL1, 16'h8000);
    rc(`ADSC_CTRL2, 16'h0004);
    rc(`ADSC_BUF_BASE, 16'h0000);
    // RC clock: auto-end sampling, conversion completes in sleep.
    wr(`ADSC_CTRL3, 16'h0180);
    irq_en <= 1'b1;
    wr(`ADSC_CTRL1, 16'h80E2);
    sleep <= 1'b1;
    for (k = 0; k < 400 && nwake == 0; k++) @(negedge core_clk);
    @(posedge core_clk);
    sleep <= 1'b0;
    chk(16'(nwake), 16'h0001);
    rc(`ADSC_BUF_BASE, fmt(2'h0, lvl(5)));
    irq_en <= 1'b0;
    wr(`ADSC_CTRL1, 16'h80E2);
    sleep <= 1'b1;
    repeat (200) @(posedge core_clk);
    #1 chk({15'h0000, active}, 16'h0000);
    @(posedge core_clk);
    sleep <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd_s <= 1'b0;
    chk(16'(nwake), 16'h0001);
    rc(`ADSC_CTRL1, 16'h80E1);
    wr(`ADSC_CTRL3, 16'h0000);
    wr(`ADSC_CTRL1, 16'h8000);
    @(posedge core_clk);
    idle <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk({15'h0000, active}, 16'h0001);
    wr(`ADSC_CTRL1, 16'hA000);
    repeat (3) @(posedge core_clk);
    #1 chk({15'h0000, active}, 16'h0000);
    @(posedge core_clk);
    idle <= 1'b0;
    wr(`ADSC_CTRL1, 16'h0000);
    repeat (3) @(posedge core_clk);
    #1 chk({15'h0000, active}, 16'h0000);
    // Free-running auto conversions: one request per two results.
    reset_dut();
    wr(`ADSC_CTRL3, 16'h0200);
    wr(`ADSC_CTRL2, 16'h0004);
    wr(`ADSC_INSEL, 16'h0005);
    base = nconv;
    k = nirq;
    wr(`ADSC_CTRL1, 16'h80E4);
    for (int n = 0; n < 600 && nirq - k < 3; n++) @(negedge core_clk);
    wr(`ADSC_CTRL1, 16'h0000);
    chk(16'(nconv - base), 16'h0006);
    rc(`ADSC_BUF_BASE, fmt(2'h0, lvl(5)));
    // Two channels in turn: channel 1 acquires while channel 0 converts.
    wr(`ADSC_INSEL, 16'h0065);
    wr(`ADSC_CTRL2, 16'h0104);
    k = nirq;
    convert();
    repeat (30) @(posedge core_clk);
    chk(16'(nirq - k), 16'h0001);
    rc(`ADSC_BUF_BASE, fmt(2'h0, lvl(5)));
    rc(`ADSC_BUF_BASE + 12'h002, fmt(2'h0, lvl(6)));
    // External trigger ends sampling; pin 7 converts its driven level.
    wr(`ADSC_INSEL, 16'h0074);
    wr(`ADSC_CTRL1, 16'h8022);
    repeat (10) @(posedge core_clk);
    rc(`ADSC_CTRL1, 16'h8022);
    trig <= 1'b1;
    repeat (40) @(posedge core_clk);
    rc(`ADSC_BUF_BASE, fmt(2'h0, lvl(4)));
    rc(`ADSC_BUF_BASE + 12'h002, {6'h00, {10{PATTERN[7]}}});
    finish_test();
  end
endmodule : adsc_top_test
